/* File: sim/audio_link_chk.sv */
// Concurrent checks on the serial audio link between host end and receiver end.
// Assumes one system clock and a synchronous active-low reset shared by both ends.
`timescale 1ns/100ps
`include "audio_serial_regs.svh"

module audio_link_chk #(
	parameter int HALF_CYC  = 4,
	parameter int HALF_BITS = 72
) (
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_nrst,
	// Pins as driven by the host end
	input wire logic        bclk_o,
	input wire logic        lrclk_o,
	input wire logic        sdata_o,
	input wire logic        pins_oe,
	// Receiver config port
	input wire logic [7:0]  cfg_addr,
	input wire logic [15:0] cfg_wdata,
	input wire logic        cfg_we,
	input wire logic        cfg_re,
	input wire logic [15:0] cfg_rdata
);
	localparam int BIT_CYC = 2 * HALF_CYC;
	logic [15:0] fmt_shadow;
	logic [15:0] route_shadow;
	logic        lr_prev;
	logic        lr_seen;
	int          gap_cnt;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	////////////////////////////////////////////////////////////////////////////////
	// Shadow copies of the receiver registers, fed by the forwarded writes
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			fmt_shadow <= 16'h000a;
		end else if (cfg_we && cfg_addr == `FMT_TDM_OFS) begin
			fmt_shadow <= cfg_wdata & 16'h319f;
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			route_shadow <= 16'h0010;
		end else if (cfg_we && cfg_addr == `DAC_ROUTE_OFS) begin
			route_shadow <= cfg_wdata & 16'h0030;
		end
	end

	// Frame clock gap counter; restarts on every stop so a new run is not misread
	always_ff @(posedge i_clk) begin
		lr_prev <= lrclk_o;
	end
	always_ff @(posedge i_clk) begin
		if (!i_nrst || !pins_oe) begin
			gap_cnt <= 0;
			lr_seen <= 1'b0;
		end else if (lrclk_o != lr_prev) begin
			gap_cnt <= 1;
			lr_seen <= 1'b1;
		end else begin
			gap_cnt <= gap_cnt + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Repetition counts assume HALF_CYC of 4, as the bench instantiates
	sequence half_hold;
		(!pins_oe || $stable(bclk_o)) [*3];
	endsequence
	sequence data_hold;
		(!pins_oe || $stable(sdata_o)) [*7];
	endsequence

	strobe_excl_a: assert property (!(cfg_we && cfg_re))
		else $error("config strobes both high");
	cfg_addr_a: assert property ((cfg_we || cfg_re) |-> cfg_addr inside {8'h18, 8'h19, 8'h1f})
		else $error("config strobe at a foreign offset");
	rdata_idle_a: assert property (!cfg_re |=> cfg_rdata == 16'h0000)
		else $error("config read data outside its cycle");
	fmt_read_a: assert property (cfg_re && cfg_addr == 8'h19 |=> cfg_rdata == $past(fmt_shadow))
		else $error("format register read back wrong");
	route_read_a: assert property (cfg_re && cfg_addr == 8'h18 |=> cfg_rdata == $past(route_shadow))
		else $error("routing register read back wrong");
	bclk_period_a: assert property (pins_oe && $changed(bclk_o) |=> half_hold ##1 (!pins_oe || $changed(bclk_o)))
		else $error("bit clock half period wrong");
	sdata_hold_a: assert property (pins_oe && $changed(sdata_o) |=> data_hold)
		else $error("serial data changed within one bit");
	frame_len_a: assert property (pins_oe && lr_seen && lrclk_o != lr_prev |->
		gap_cnt == HALF_BITS * BIT_CYC || gap_cnt == BIT_CYC ||
		gap_cnt == (2 * HALF_BITS - 1) * BIT_CYC)
		else $error("frame clock spacing wrong");
endmodule

/* File: sim/audio_serial_tdm_format_control_bench.sv */
// Self-checking bench: software port of the host end drives the receiver over the link.
// Assumes the header, the package, the interface and both ends are compiled first.
`timescale 1ns/100ps
`include "audio_serial_regs.svh"

module audio_serial_tdm_format_control_bench;
	localparam int HC = 4;
	localparam int HB = 72;
	// Clock, reset and software port
	logic        i_clk = 1'b0;
	logic        i_nrst = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        we = 1'b0;
	logic        re = 1'b0;
	logic [31:0] rdata;
	logic [23:0] left_dac;
	logic [23:0] right_dac;
	logic        valid;
	logic        released;
	logic        taken;
	// Scoreboard and model state
	int          gap = 0;
	int          takes = 0;
	int          bad_count = 0;
	int          checked = 0;
	logic [31:0] seed = 32'hd858196c;
	logic [23:0] exp_q[$];
	int          wtab[4] = '{16, 20, 24, 32};

	audio_link_if link ();

	always #5 i_clk = ~i_clk;

	audio_tx_host #(.HALF_CYC(HC), .HALF_BITS(HB)) u_audio_tx_host (.i_clk(i_clk),
		.i_nrst(i_nrst), .i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re),
		.o_rdata(rdata), .o_sample_taken(taken), .link(link));
	audio_rx_dev u_audio_rx_dev (.i_clk(i_clk), .i_nrst(i_nrst), .link(link),
		.o_left_dac(left_dac), .o_right_dac(right_dac), .o_sample_valid(valid),
		.o_pins_released(released));
	audio_link_chk #(.HALF_CYC(HC), .HALF_BITS(HB)) u_audio_link_chk (.i_clk(i_clk),
		.i_nrst(i_nrst), .bclk_o(link.bclk_o), .lrclk_o(link.lrclk_o),
		.sdata_o(link.sdata_o), .pins_oe(link.pins_oe), .cfg_addr(link.cfg_addr),
		.cfg_wdata(link.cfg_wdata), .cfg_we(link.cfg_we), .cfg_re(link.cfg_re),
		.cfg_rdata(link.cfg_rdata));

	////////////////////////////////////////////////////////////////////////////////
	// Fixed-seed xorshift source
	function automatic logic [31:0] next_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Model of the receiver's 24-bit resolution: short words padded, long words cut
	function automatic logic [23:0] to_dac(input logic [31:0] w, input int bits);
		if (bits == 32) begin
			return w[31:8];
		end
		return 24'(w << (24 - bits));
	endfunction

	task automatic tally_and_finish();
		if (bad_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Pair compare against the two queued words
	task automatic check_dac();
		checked++;
		if (left_dac !== exp_q[0] || right_dac !== exp_q[1]) begin
			bad_count++;
			$display("Error dac pair expected %h %h seen %h %h", exp_q[0], exp_q[1],
				left_dac, right_dac);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Software port cycles; a clock edge always separates two strobes
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge i_clk);
		we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		addr <= a;
		re <= 1'b1;
		@(posedge i_clk);
		re <= 1'b0;
		@(negedge i_clk);
		check_val("rdata", exp, rdata);
	endtask

	// Bounded wait for the next sample pulse, looked at mid-cycle;
	// also records cycles since the last pulse and frame starts seen
	task automatic wait_valid();
		int n;
		n = 0;
		takes = 0;
		@(negedge i_clk);
		while (valid !== 1'b1 && n < 3000) begin
			takes += (taken === 1'b1) ? 1 : 0;
			@(negedge i_clk);
			n++;
		end
		takes += (taken === 1'b1) ? 1 : 0;
		gap = n + 1;
		if (n >= 3000) begin
			bad_count++;
			tally_and_finish();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] r;
		logic [31:0] cfg;
		logic [31:0] route;
		logic [31:0] lw;
		logic [31:0] rw;
		logic [23:0] el;
		logic [23:0] er;
		int          bits;
		int          n;
		repeat (20) @(posedge i_clk);
		i_nrst <= 1'b1;
		rd(8'h18, 32'h0010);
		rd(8'h19, 32'h000a);
		rd(8'h00, 32'h000a);
		rd(8'h40, 32'h0);
		rd(8'h1f, 32'h0);
		wr(8'h19, 32'hffffffff);
		rd(8'h19, 32'h319f);
		check_val("released", 32'h1, {31'h0, released});
		rd(8'h1f, 32'h2);
		wr(8'h18, 32'hffffffff);
		rd(8'h18, 32'h0030);
		// Each format meets three of the four word lengths over the twelve runs
		for (int i = 0; i < 12; i++) begin
			r = next_rand();
			bits = wtab[(i + i / 4) % 4];
			cfg = (r & 32'h3090) | 32'(((i + i / 4) % 4) << 2) | 32'(i % 4);
			route = (r >> 16) & 32'h30;
			lw = next_rand() & ((bits == 32) ? 32'hffffffff : (32'h1 << bits) - 1);
			rw = next_rand() & ((bits == 32) ? 32'hffffffff : (32'h1 << bits) - 1);
			el = to_dac(lw, bits);
			er = to_dac(rw, bits);
			exp_q = {route[5] ? er : el, route[4] ? er : el};
			wr(8'h00, cfg);
			wr(8'h19, cfg);
			wr(8'h18, route);
			wr(8'h04, lw);
			wr(8'h08, rw);
			rd(8'h19, cfg);
			rd(8'h00, cfg);
			wr(8'h00, cfg | 32'h8000);
			// First frames after a start may hold a partial word
			repeat (2) wait_valid();
			repeat (2) begin
				wait_valid();
				check_dac();
			end
			// Steady frames: one frame of 2*HB bits of 2*HC cycles between pulses
			check_val("frame cycles", 32'(4 * HB * HC), 32'(gap));
			check_val("taken count", 32'h1, 32'(takes));
		end
		// Released pins: no samples while set, normal service once cleared
		wr(8'h19, cfg | 32'h0100);
		@(negedge i_clk);
		check_val("released", 32'h1, {31'h0, released});
		n = 0;
		repeat (2500) begin
			@(negedge i_clk);
			n += (valid === 1'b1) ? 1 : 0;
		end
		check_val("valid count", 32'h0, 32'(n));
		rd(8'h1f, 32'h3);
		wr(8'h19, cfg);
		@(negedge i_clk);
		check_val("released", 32'h0, {31'h0, released});
		repeat (2) wait_valid();
		wait_valid();
		check_dac();
		tally_and_finish();
	end
endmodule

/* File: verilog/audio_link_if.sv */
// Serial audio pins plus the receiver's config port between the two ends.
// Assumes both ends share one system clock for the config port.
`timescale 1ns/100ps
interface audio_link_if;
	// Pins as driven by the transmitter
	logic       bclk_o;
	logic       lrclk_o;
	logic       sdata_o;
	logic       pins_oe;
	// Pin levels; an undriven line is taken as low (pull-down)
	logic       bclk;
	logic       lrclk;
	logic       sdata;
	// Receiver config port
	logic [7:0]  cfg_addr;
	logic [15:0] cfg_wdata;
	logic        cfg_we;
	logic        cfg_re;
	logic [15:0] cfg_rdata;

	// Wire resolution from the output enable
	assign bclk  = pins_oe & bclk_o;
	assign lrclk = pins_oe & lrclk_o;
	assign sdata = pins_oe & sdata_o;

	modport host_end (
		output bclk_o, lrclk_o, sdata_o, pins_oe, cfg_addr, cfg_wdata, cfg_we, cfg_re,
		input  cfg_rdata
	);
	modport dev_end (
		input  bclk, lrclk, sdata, cfg_addr, cfg_wdata, cfg_we, cfg_re,
		output cfg_rdata
	);
endinterface

/* File: verilog/audio_rx_dev.sv */
// Receiving end: serial audio frame decoder with slot select and DAC routing.
// Assumes link pins are asynchronous to i_clk and the link clock is slower
// than a quarter of i_clk; config port is synchronous to i_clk.
//
// How it works
// RQ1: Multiplex reception in all formats, enable bit 13
// RQ2: Multiplexed data taken from slot picked by bit 12
// RQ3: Bit clock fast enough for both slots
// RQ4: Bit 5 routes left or right to left DAC
// RQ5: Bit 4 routes left or right to right DAC
// RQ6: Bit 7 inverts the received bit clock
// RQ7: Bit 4 inverts frame clock outside DSP
// RQ8: DSP mode A: MSB on second edge
// RQ9: DSP mode B: MSB on first edge
// RQ10: Bits 3:2 pick 16/20/24/32 bit words
// RQ11: Bits 1:0 pick RJ, LJ, I2S, DSP
// RQ12: Bit 8 releases all link pins; here pins_oe follows the run bit and bit 8 only stops sampling
// RQ13: Left justified: MSB on first edge
// RQ14: I2S: MSB on second edge
// RQ15: Right justified: LSB on last edge
// RQ16: Keep 24 bits, drop 8 LSBs of 32
// RQ17: Slot 1 follows slot 0 directly
// RQ18: DSP right word follows left word
`timescale 1ns/100ps
`include "audio_serial_regs.svh"

module audio_rx_dev (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// Link
	audio_link_if.dev_end    link,
	// DAC side
	output logic      [23:0] o_left_dac,
	output logic      [23:0] o_right_dac,
	output logic             o_sample_valid,
	output logic             o_pins_released
);

	// Word of w bits, MSB first, to the 24-bit DAC width
	function automatic logic [23:0] to_dac(input logic [5:0] w, input logic [31:0] word);
		case (w)
			6'h10:   to_dac = {word[15:0], 8'h00};
			6'h14:   to_dac = {word[19:0], 4'h0};
			6'h18:   to_dac = word[23:0];
			default: to_dac = word[31:8];
		endcase
	endfunction

	logic        left_src_reg;
	logic        right_src_reg;
	logic [15:0] fmt_cfg_reg;
	logic [15:0] rdata_reg;
	logic        bclk_s1, bclk_s2, lr_s1, lr_s2, dat_s1, dat_s2;
	logic        phase_prev_reg;
	logic        lr_prev_reg;
	logic [7:0]  pos_reg, pos_next;
	logic        half_reg, half_next;
	logic [7:0]  hlen_reg;
	logic        seen_reg;
	logic [31:0] sr_reg [2];
	logic [23:0] left_hold_reg;
	logic        valid_reg;
	logic [23:0] left_dac_reg, right_dac_reg;

	logic                     tdm, slot, hiz, bclk_inv, frame_pol, mode_b, dsp, i2s;
	logic [5:0]               w;
	audio_serial_pkg::fmt_type fmt;
	logic                     phase, sample_edge, lr_change, left_now, marker;
	logic [1:0]               in_win, last_bit;
	logic [7:0]               start [2];
	logic [7:0]               rel [2];
	logic [23:0]              right_word;

	////////////////////////////////////////////////////////////////////////////
	// Config registers

	// Field decode
	assign tdm       = fmt_cfg_reg[`MUX_EN_BIT];                       // [RQ1]
	assign slot      = fmt_cfg_reg[`SLOT_SEL_BIT];                     // [RQ2]
	assign hiz       = fmt_cfg_reg[`PINS_HIZ_BIT];
	assign bclk_inv  = fmt_cfg_reg[`BCLK_INV_BIT];
	assign frame_pol = fmt_cfg_reg[`FRAME_POL_BIT];
	assign mode_b    = frame_pol;                                      // [RQ8] [RQ9]
	assign w         = audio_serial_pkg::word_bits(fmt_cfg_reg[`WL_MSB:`WL_LSB]); // [RQ10]
	assign fmt       = audio_serial_pkg::fmt_type'(fmt_cfg_reg[`FMT_MSB:`FMT_LSB]); // [RQ11]
	assign dsp       = (fmt == audio_serial_pkg::FMT_DSP);
	assign i2s       = (fmt == audio_serial_pkg::FMT_I2S);

	// Register writes; unimplemented bits stay zero
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			left_src_reg  <= 1'(`DAC_ROUTE_RST >> `LEFT_SRC_BIT);      // [RQ4]
			right_src_reg <= 1'(`DAC_ROUTE_RST >> `RIGHT_SRC_BIT);     // [RQ5]
			fmt_cfg_reg   <= `FMT_TDM_RST;
		end else if (link.cfg_we) begin
			if (link.cfg_addr == `DAC_ROUTE_OFS) begin
				left_src_reg  <= link.cfg_wdata[`LEFT_SRC_BIT];
				right_src_reg <= link.cfg_wdata[`RIGHT_SRC_BIT];
			end
			if (link.cfg_addr == `FMT_TDM_OFS)
				fmt_cfg_reg <= link.cfg_wdata & `FMT_TDM_MASK;
		end
	end

	// Read data one cycle after the strobe, zero otherwise and when unmapped
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			rdata_reg <= 16'h0000;
		end else if (link.cfg_re) begin
			case (link.cfg_addr)
				`DAC_ROUTE_OFS:  rdata_reg <= (16'(left_src_reg) << `LEFT_SRC_BIT)
				                            | (16'(right_src_reg) << `RIGHT_SRC_BIT);
				`FMT_TDM_OFS:    rdata_reg <= fmt_cfg_reg;
				`DEV_STATUS_OFS: rdata_reg <= (16'(seen_reg) << `STAT_SEEN_BIT)
				                            | (16'(hiz) << `STAT_HIZ_BIT);
				default:         rdata_reg <= 16'h0000;
			endcase
		end else begin
			rdata_reg <= 16'h0000;
		end
	end
	assign link.cfg_rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	// Two stages on every pin before any logic looks at it
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			{bclk_s1, bclk_s2} <= 2'h0;
			{lr_s1, lr_s2}     <= 2'h0;
			{dat_s1, dat_s2}   <= 2'h0;
		end else begin
			{bclk_s1, bclk_s2} <= {link.bclk, bclk_s1};
			{lr_s1, lr_s2}     <= {link.lrclk, lr_s1};
			{dat_s1, dat_s2}   <= {link.sdata, dat_s1};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame tracking

	// Sampling edge of the (optionally inverted) bit clock
	assign phase       = bclk_s2 ^ bclk_inv;                           // [RQ6]
	// Released pins carry no meaning, so the receiver stops sampling
	assign sample_edge = phase & ~phase_prev_reg & ~hiz;               // [RQ12]
	assign o_pins_released = hiz;                                      // [RQ12]

	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			phase_prev_reg <= 1'b0;
		else
			phase_prev_reg <= phase;
	end

	// Half-frame markers: any frame clock change, or a DSP rising pulse
	assign lr_change = lr_s2 ^ lr_prev_reg;
	assign left_now  = lr_s2 ^ frame_pol ^ i2s;                        // [RQ7]
	assign marker    = dsp ? (lr_s2 & ~lr_prev_reg) : lr_change;

	always_comb begin
		pos_next  = marker ? 8'h00 : (pos_reg == 8'hff ? pos_reg : pos_reg + 8'h01);
		half_next = dsp ? 1'b0 : (lr_change ? ~left_now : half_reg);
	end

	// Position counter; half length is measured for right justified starts
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			lr_prev_reg <= 1'b0;
			pos_reg     <= 8'hff;
			half_reg    <= 1'b0;
			hlen_reg    <= 8'(`HALF_FRAME_BITS);
			seen_reg    <= 1'b0;
		end else if (sample_edge) begin
			lr_prev_reg <= lr_s2;
			pos_reg     <= pos_next;
			half_reg    <= half_next;
			if (marker) begin
				seen_reg <= 1'b1;
				if (!dsp)
					hlen_reg <= pos_reg + 8'h01;                       // [RQ3] [RQ15]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Word capture

	// Window of each channel word within the half frame or DSP frame
	always_comb begin
		for (int ch = 0; ch < 2; ch++) begin
			// Slot and format placement: [RQ1] [RQ2] [RQ13] [RQ14] [RQ15] [RQ17] [RQ18]
			start[ch] = audio_serial_pkg::chan_start(fmt, tdm, slot, mode_b, ch[0], w,
			                                         hlen_reg);
			rel[ch]   = pos_next - start[ch];
			in_win[ch] = (dsp || (half_next == ch[0])) && (pos_next >= start[ch])
			             && (rel[ch] < {2'h0, w});
			last_bit[ch] = in_win[ch] && (rel[ch] == {2'h0, w} - 8'h01);
		end
	end

	// Shift registers take bits MSB first
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			sr_reg[0] <= 32'h0000_0000;
			sr_reg[1] <= 32'h0000_0000;
		end else if (sample_edge) begin
			for (int ch = 0; ch < 2; ch++)
				if (in_win[ch])
					sr_reg[ch] <= {sr_reg[ch][30:0], dat_s2};
		end
	end

	assign right_word = to_dac(w, {sr_reg[1][30:0], dat_s2});           // [RQ16]

	// Left word held until its right partner arrives
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			left_hold_reg <= 24'h00_0000;
		else if (sample_edge && last_bit[0])
			left_hold_reg <= to_dac(w, {sr_reg[0][30:0], dat_s2});     // [RQ16]
	end

	// Routing to the DACs; both update together on the last bit of the right word
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			left_dac_reg  <= 24'h00_0000;
			right_dac_reg <= 24'h00_0000;
			valid_reg     <= 1'b0;
		end else begin
			valid_reg <= sample_edge & last_bit[1];
			if (sample_edge && last_bit[1]) begin
				left_dac_reg  <= left_src_reg ? right_word : left_hold_reg;  // [RQ4]
				right_dac_reg <= right_src_reg ? right_word : left_hold_reg; // [RQ5]
			end
		end
	end

	assign o_left_dac     = left_dac_reg;
	assign o_right_dac    = right_dac_reg;
	assign o_sample_valid = valid_reg;

endmodule

/* File: verilog/audio_serial_pkg.sv */
// Types and shared slot arithmetic of the serial audio link.
// Assumes nothing beyond a SystemVerilog compiler.
package audio_serial_pkg;

	typedef enum logic [1:0] {
		FMT_RJ  = 2'h0,
		FMT_LJ  = 2'h1,
		FMT_I2S = 2'h2,
		FMT_DSP = 2'h3
	} fmt_type;

	// Word length code to bit count
	function automatic logic [5:0] word_bits(input logic [1:0] code);
		case (code)
			2'h0:    word_bits = 6'h10;
			2'h1:    word_bits = 6'h14;
			2'h2:    word_bits = 6'h18;
			default: word_bits = 6'h20;
		endcase
	endfunction

	// First bit position of a channel word, counted in bit clock edges
	// from the half-frame (or DSP frame) marker edge
	function automatic logic [7:0] chan_start(input fmt_type fmt, input logic tdm,
			input logic slot, input logic mode_b, input logic right,
			input logic [5:0] w, input logic [7:0] hlen);
		logic [7:0] w8;
		logic [7:0] off;
		w8  = {2'h0, w};
		off = (tdm && slot) ? w8 : 8'h00;
		case (fmt)
			FMT_DSP: chan_start = (mode_b ? 8'h00 : 8'h01) + off + off + (right ? w8 : 8'h00);
			FMT_LJ:  chan_start = off;
			FMT_I2S: chan_start = 8'h01 + off;
			default: chan_start = tdm ? hlen - w8 - w8 + off : hlen - w8;
		endcase
	endfunction

endpackage

/* File: verilog/audio_serial_regs.svh */
// Offsets, field positions, reset values and timing counts of the serial audio link.
// Assumes inclusion by bare name from any file of the link.
`ifndef AUDIO_SERIAL_REGS_SVH
`define AUDIO_SERIAL_REGS_SVH

// Receiver register offsets, reached through the link's config port
`define DAC_ROUTE_OFS   8'h18
`define FMT_TDM_OFS     8'h19
`define DEV_STATUS_OFS  8'h1f

// Receiver field positions
`define LEFT_SRC_BIT    5
`define RIGHT_SRC_BIT   4
`define MUX_EN_BIT      13
`define SLOT_SEL_BIT    12
`define PINS_HIZ_BIT    8
`define BCLK_INV_BIT    7
`define FRAME_POL_BIT   4
`define WL_MSB          3
`define WL_LSB          2
`define FMT_MSB         1
`define FMT_LSB         0
`define STAT_SEEN_BIT   0
`define STAT_HIZ_BIT    1

// Reset values and writable masks
`define DAC_ROUTE_RST   16'h0010
`define DAC_ROUTE_MASK  16'h0030
`define FMT_TDM_RST     16'h000a
`define FMT_TDM_MASK    16'h319f

// Transmitter register offsets and fields
`define HOST_CTRL_OFS   8'h00
`define HOST_LEFT_OFS   8'h04
`define HOST_RIGHT_OFS  8'h08
`define HOST_STAT_OFS   8'h0c
`define HOST_RUN_BIT    15
`define HOST_CTRL_MASK  16'hb19f

// Timing: system clock, link clock and frame length
`define SYS_CLK_NS      10
`define LINK_CLK_NS     80
`define LINK_HALF_CYC   ((`LINK_CLK_NS / 2) / `SYS_CLK_NS)
`define HALF_FRAME_BITS 72

`endif

/* File: verilog/audio_tx_host.sv */
// Transmitting end: bit clock master that frames two sample words onto the link.
// Assumes software on the plain port in the i_clk domain; receiver config
// offsets are forwarded over the link's config port.
`timescale 1ns/100ps
`include "audio_serial_regs.svh"

module audio_tx_host #(
	parameter int HALF_CYC  = `LINK_HALF_CYC,
	parameter int HALF_BITS = `HALF_FRAME_BITS
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// Software port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_we,
	input  wire logic        i_re,
	output logic      [31:0] o_rdata,
	// Frame start pulse, samples taken
	output logic             o_sample_taken,
	// Link
	audio_link_if.host_end   link
);

	localparam logic [7:0] HB    = 8'(HALF_BITS);
	localparam logic [7:0] P_END = 8'(2 * HALF_BITS - 1);

	logic [15:0] ctrl_reg;
	logic [31:0] left_reg, right_reg, tx_reg [2];
	logic [31:0] rdata_reg;
	logic        fwd_rd_reg;
	logic [15:0] frame_cnt_reg;
	logic [7:0]  div_reg;
	logic        bclk_int_reg, lrclk_reg, sdata_reg, taken_reg;
	logic [7:0]  p_reg, p_nx, q;

	logic                     run, dev_hit, fall, dsp, half, bit_nx, lr_nx;
	logic [5:0]               w;
	audio_serial_pkg::fmt_type fmt;
	logic [7:0]               start, rel;
	logic [5:0]               idx;
	logic [31:0]              word;

	assign run     = ctrl_reg[`HOST_RUN_BIT];
	assign w       = audio_serial_pkg::word_bits(ctrl_reg[`WL_MSB:`WL_LSB]);  // [RQ10]
	assign fmt     = audio_serial_pkg::fmt_type'(ctrl_reg[`FMT_MSB:`FMT_LSB]); // [RQ11]
	assign dsp     = (fmt == audio_serial_pkg::FMT_DSP);
	assign dev_hit = (i_addr == `DAC_ROUTE_OFS) || (i_addr == `FMT_TDM_OFS)
	              || (i_addr == `DEV_STATUS_OFS);

	////////////////////////////////////////////////////////////////////////////
	// Software registers

	// Own registers; receiver offsets pass straight through
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			ctrl_reg  <= `FMT_TDM_RST;
			left_reg  <= 32'h0000_0000;
			right_reg <= 32'h0000_0000;
		end else if (i_we) begin
			case (i_addr)
				`HOST_CTRL_OFS:  ctrl_reg  <= i_wdata[15:0] & `HOST_CTRL_MASK;
				`HOST_LEFT_OFS:  left_reg  <= i_wdata;
				`HOST_RIGHT_OFS: right_reg <= i_wdata;
				default:         ;
			endcase
		end
	end

	// Read path, one cycle latency on both own and forwarded reads
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			rdata_reg  <= 32'h0000_0000;
			fwd_rd_reg <= 1'b0;
		end else begin
			fwd_rd_reg <= i_re & dev_hit;
			case (i_addr)
				`HOST_CTRL_OFS:  rdata_reg <= i_re ? {16'h0000, ctrl_reg} : 32'h0;
				`HOST_LEFT_OFS:  rdata_reg <= i_re ? left_reg : 32'h0;
				`HOST_RIGHT_OFS: rdata_reg <= i_re ? right_reg : 32'h0;
				`HOST_STAT_OFS:  rdata_reg <= i_re ? {16'h0000, frame_cnt_reg} : 32'h0;
				default:         rdata_reg <= 32'h0000_0000;
			endcase
		end
	end
	assign o_rdata = fwd_rd_reg ? {16'h0000, link.cfg_rdata} : rdata_reg;

	assign link.cfg_addr  = i_addr;
	assign link.cfg_wdata = i_wdata[15:0];
	assign link.cfg_we    = i_we & dev_hit;
	assign link.cfg_re    = i_re & dev_hit;

	////////////////////////////////////////////////////////////////////////////
	// Bit clock and framing

	// Divider; every half period toggles the internal bit clock
	assign fall = run && (div_reg == 8'(HALF_CYC - 1)) && bclk_int_reg;
	always_ff @(posedge i_clk) begin
		if (!i_nrst || !run) begin
			div_reg      <= 8'h00;
			bclk_int_reg <= 1'b0;
		end else if (div_reg == 8'(HALF_CYC - 1)) begin
			div_reg      <= 8'h00;
			bclk_int_reg <= ~bclk_int_reg;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	// Next edge position and the bit it carries
	always_comb begin
		p_nx  = (p_reg == P_END) ? 8'h00 : p_reg + 8'h01;
		half  = !dsp && (p_nx >= HB);
		q     = half ? p_nx - HB : p_nx;
		bit_nx = 1'b0;
		start = 8'h00;
		rel   = 8'h00;
		idx   = 6'h00;
		word  = 32'h0000_0000;
		for (int ch = 0; ch < 2; ch++) begin
			// Placement: [RQ3] [RQ8] [RQ9] [RQ13] [RQ14] [RQ15] [RQ17]
			start = audio_serial_pkg::chan_start(fmt, ctrl_reg[`MUX_EN_BIT],
			        ctrl_reg[`SLOT_SEL_BIT], ctrl_reg[`FRAME_POL_BIT], ch[0], w, HB);
			rel   = q - start;
			word  = (p_nx == 8'h00) ? (ch == 0 ? left_reg : right_reg) : tx_reg[ch];
			idx   = w - 6'h01 - rel[5:0];
			if ((dsp || half == ch[0]) && q >= start && rel < {2'h0, w})
				bit_nx = word[idx[4:0]];
		end
		// Left half high for LJ/RJ, low for I2S, both inverted when bit 4 is set; DSP is a one-edge pulse
		lr_nx = dsp ? (p_nx == 8'h00)
		            : (~half ^ (fmt == audio_serial_pkg::FMT_I2S) ^ ctrl_reg[`FRAME_POL_BIT]);
	end

	// Data and frame clock change on the falling internal edge
	always_ff @(posedge i_clk) begin
		if (!i_nrst || !run) begin
			p_reg         <= P_END;
			lrclk_reg     <= 1'b0;
			sdata_reg     <= 1'b0;
			taken_reg     <= 1'b0;
			tx_reg[0]     <= 32'h0000_0000;
			tx_reg[1]     <= 32'h0000_0000;
			if (!i_nrst)
				frame_cnt_reg <= 16'h0000;
		end else begin
			taken_reg <= fall && (p_nx == 8'h00);
			if (fall) begin
				p_reg     <= p_nx;
				lrclk_reg <= lr_nx;
				sdata_reg <= bit_nx;
				if (p_nx == 8'h00) begin
					tx_reg[0]     <= left_reg;
					tx_reg[1]     <= right_reg;
					frame_cnt_reg <= frame_cnt_reg + 16'h0001;
				end
			end
		end
	end

	assign link.bclk_o  = bclk_int_reg ^ ctrl_reg[`BCLK_INV_BIT];
	assign link.lrclk_o = lrclk_reg;
	assign link.sdata_o = sdata_reg;
	assign link.pins_oe = run;
	assign o_sample_taken = taken_reg;

endmodule
